/* verilog/amd_params.svh */
// Function
// [RULE1] Source bit 0 selects automatic depth calibration
// [RULE2] Bits 6..1 hold target depth ratio
// [RULE3] Target equals amplitude divided by 1.xxxxxx
// [RULE4] Host programs 001110 for ten percent
// [RULE5] Driver has eight binary weighted segments
// [RULE6] Host starts oscillator and regulators first
// [RULE7] Calibration enables transmitter, measures unmodulated carrier
// [RULE8] Target level computed from amplitude and ratio
// [RULE9] Successive approximation tunes driver toward target
// [RULE10] Result copied to display, used for modulation
// [RULE11] Host keeps normal level after calibration
// [RULE12] Host runs antenna calibration before depth
// [RULE13] Source bit 1 uses written modulated level
// [RULE14] Host calibrates manually beyond thirty three percent
// [RULE15] Manual start: normal level, transmitter, measure
// [RULE16] Manual loop: modify, measure, compare, repeat
// [RULE17] Manual end: store modulated, restore normal
// [RULE18] Equal weight tuning switches share one source
// [RULE19] Tuning set by calibration or control register
// [RULE20] Approximation resolves segment bits MSB first
// [RULE21] Completion flag raised when display written
`ifndef AMD_PARAMS_SVH
`define AMD_PARAMS_SVH
`define AMD_OFS_DEPTH_CTRL 8'h00
`define AMD_OFS_NORMAL_LVL 8'h04
`define AMD_OFS_MOD_LVL 8'h08
`define AMD_OFS_DISPLAY 8'h0c
`define AMD_OFS_ADC_OUT 8'h10
`define AMD_OFS_TX_CTRL 8'h14
`define AMD_OFS_COMMAND 8'h18
`define AMD_OFS_STATUS 8'h1c
`define AMD_OFS_ANT_CTRL 8'h20
`define AMD_OFS_ANT_TARGET 8'h24
`define AMD_OFS_ANT_DISPLAY 8'h28
`define AMD_BIT_SOURCE 7
`define AMD_BIT_RATIO_HI 6
`define AMD_BIT_RATIO_LO 1
`define AMD_BIT_ANT_MANUAL 7
`define AMD_CMD_CAL_DEPTH 0
`define AMD_CMD_MEASURE 1
`define AMD_CMD_CAL_ANT 2
`define AMD_ST_BUSY 0
`define AMD_ST_DEPTH_DONE 1
`define AMD_ST_MEAS_DONE 2
`define AMD_ST_ANT_DONE 3
`define AMD_RST_BYTE 8'h00
`define AMD_ANT_TOL 8'h04
`define AMD_CLK_PERIOD_NS 25
`define AMD_SETTLE_NS 10000
`define AMD_SETTLE_CYC ((`AMD_SETTLE_NS + `AMD_CLK_PERIOD_NS - 1) / `AMD_CLK_PERIOD_NS)
`endif

/* verilog/amd_pkg.sv */
package amd_pkg;

    typedef enum logic [2:0]
    {
        AMD_IDLE = 3'h0,
        AMD_SETTLE = 3'h1,
        AMD_START = 3'h3,
        AMD_WAIT = 3'h2,
        AMD_EVAL = 3'h6
    } amd_fsm_type;

    typedef enum logic [1:0]
    {
        AMD_JOB_UNMOD = 2'h0,
        AMD_JOB_SAR = 2'h1,
        AMD_JOB_MANUAL = 2'h3,
        AMD_JOB_ANT = 2'h2
    } amd_job_type;

    typedef struct packed
    {
        logic tx_enable;
        logic [7:0] seg_on_a;
        logic [7:0] seg_on_b;
    } amd_driver_type;

    typedef struct packed
    {
        logic start;
        logic phase_sel;
    } amd_adc_req_type;

endpackage

/* verilog/amd_depth_cal.sv */
`timescale 1ns/10ps
`include "amd_params.svh"

module amd_depth_cal
    import amd_pkg::*;
(
    input wire logic pclk, // APB clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic tx_am_modulate, // Framing asks for modulated level
    input wire logic adc_done, // Converter conversion finished
    input wire logic [7:0] adc_data, // Converter result
    output amd_adc_req_type adc_req, // Converter start and mode
    output logic tx_enable, // Transmitter on
    output logic [7:0] antenna_driver_out_a, // Segment enables, driver a
    output logic [7:0] antenna_driver_out_b, // Segment enables, driver b
    output logic [3:0] tuning_switch_bank_a, // Tuning switches, bank a
    output logic [3:0] tuning_switch_bank_b // Tuning switches, bank b
);

    ////////////////////////////////////////////////////////////////////////

    typedef struct packed
    {
        logic [7:0] depth_ctrl;
        logic [7:0] normal_lvl;
        logic [7:0] mod_lvl;
        logic [7:0] display;
        logic [7:0] adc_out;
        logic [7:0] target;
        logic [7:0] trial;
        logic [7:0] ant_ctrl;
        logic [7:0] ant_target;
        logic [4:0] ant_display;
        logic tx_on;
        logic depth_done;
        logic meas_done;
        logic ant_done;
        amd_fsm_type fsm;
        amd_job_type job;
        logic [2:0] bit_idx;
        logic [8:0] settle_cnt;
        logic done_s1;
        logic done_s2;
        logic done_prev;
        logic [7:0] data_s1;
        logic [7:0] data_s2;
        logic [31:0] prdata;
        logic pslverr;
        logic adc_start;
        amd_driver_type drv;
    } amd_regs_type;

    amd_regs_type state_ff;
    amd_regs_type nxt_state;

    ////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        logic done_edge;
        logic busy;
        logic hit;
        logic wr;
        logic [7:0] rd;
        logic [7:0] kept;
        logic [7:0] level;
        logic [7:0] diff;
        logic [13:0] quot;
        done_edge = 1'b0;
        busy = 1'b0;
        hit = 1'b0;
        wr = 1'b0;
        rd = 8'h00;
        kept = 8'h00;
        level = 8'h00;
        diff = 8'h00;
        quot = 14'h0000;
        nxt_state = state_ff;
        nxt_state.adc_start = 1'b0;

        // Converter handshake crosses from the analog side.
        nxt_state.done_s1 = adc_done;
        nxt_state.done_s2 = state_ff.done_s1;
        nxt_state.done_prev = state_ff.done_s2;
        nxt_state.data_s1 = adc_data;
        nxt_state.data_s2 = state_ff.data_s1;
        done_edge = state_ff.done_s2 & ~state_ff.done_prev;
        busy = (state_ff.fsm != AMD_IDLE);

        // Address decode and read data, latched in the setup cycle.
        case (paddr)
            `AMD_OFS_DEPTH_CTRL:
            begin
                hit = 1'b1;
                rd = state_ff.depth_ctrl;
            end
            `AMD_OFS_NORMAL_LVL:
            begin
                hit = 1'b1;
                rd = state_ff.normal_lvl;
            end
            `AMD_OFS_MOD_LVL:
            begin
                hit = 1'b1;
                rd = state_ff.mod_lvl;
            end
            `AMD_OFS_DISPLAY:
            begin
                hit = 1'b1;
                rd = state_ff.display;
            end
            `AMD_OFS_ADC_OUT:
            begin
                hit = 1'b1;
                rd = state_ff.adc_out;
            end
            `AMD_OFS_TX_CTRL:
            begin
                hit = 1'b1;
                rd = {7'h00, state_ff.tx_on};
            end
            `AMD_OFS_COMMAND: hit = 1'b1;
            `AMD_OFS_STATUS:
            begin
                hit = 1'b1;
                rd = {4'h0, state_ff.ant_done, state_ff.meas_done,
                    state_ff.depth_done, busy};
            end
            `AMD_OFS_ANT_CTRL:
            begin
                hit = 1'b1;
                rd = state_ff.ant_ctrl;
            end
            `AMD_OFS_ANT_TARGET:
            begin
                hit = 1'b1;
                rd = state_ff.ant_target;
            end
            `AMD_OFS_ANT_DISPLAY:
            begin
                hit = 1'b1;
                rd = {3'h0, state_ff.ant_display};
            end
            default: hit = 1'b0;
        endcase
        if (psel && !penable)
        begin
            nxt_state.prdata = {24'h000000, rd};
            nxt_state.pslverr = ~hit;
        end

        // Register writes take effect in the access cycle.
        wr = psel & penable & pwrite;
        if (wr)
        begin
            case (paddr)
                `AMD_OFS_DEPTH_CTRL: nxt_state.depth_ctrl = pwdata[7:0];
                `AMD_OFS_NORMAL_LVL: nxt_state.normal_lvl = pwdata[7:0];
                `AMD_OFS_MOD_LVL: nxt_state.mod_lvl = pwdata[7:0];
                `AMD_OFS_TX_CTRL: nxt_state.tx_on = pwdata[0];
                `AMD_OFS_ANT_CTRL: nxt_state.ant_ctrl = pwdata[7:0];
                `AMD_OFS_ANT_TARGET: nxt_state.ant_target = pwdata[7:0];
                `AMD_OFS_STATUS:
                begin
                    if (pwdata[`AMD_ST_DEPTH_DONE])
                    begin
                        nxt_state.depth_done = 1'b0;
                    end
                    if (pwdata[`AMD_ST_MEAS_DONE])
                    begin
                        nxt_state.meas_done = 1'b0;
                    end
                    if (pwdata[`AMD_ST_ANT_DONE])
                    begin
                        nxt_state.ant_done = 1'b0;
                    end
                end
                default: nxt_state.pslverr = state_ff.pslverr;
            endcase
        end

        // Sequencer. Commands arriving while busy are ignored.
        case (state_ff.fsm)
            AMD_IDLE:
            begin
                if (wr && paddr == `AMD_OFS_COMMAND)
                begin
                    if (pwdata[`AMD_CMD_CAL_DEPTH] && !state_ff.depth_ctrl[`AMD_BIT_SOURCE])
                    begin
                        nxt_state.job = AMD_JOB_UNMOD; // RULE1
                        nxt_state.trial = `AMD_RST_BYTE;
                        nxt_state.fsm = AMD_SETTLE; // RULE7
                        nxt_state.settle_cnt = 9'(`AMD_SETTLE_CYC);
                    end
                    else if (pwdata[`AMD_CMD_MEASURE])
                    begin
                        nxt_state.job = AMD_JOB_MANUAL; // RULE15
                        nxt_state.fsm = AMD_START;
                    end
                    else if (pwdata[`AMD_CMD_CAL_ANT])
                    begin
                        nxt_state.job = AMD_JOB_ANT; // RULE19
                        nxt_state.trial = 8'h08;
                        nxt_state.bit_idx = 3'h3;
                        nxt_state.fsm = AMD_SETTLE;
                        nxt_state.settle_cnt = 9'(`AMD_SETTLE_CYC);
                    end
                end
            end
            AMD_SETTLE:
            begin
                if (state_ff.settle_cnt <= 9'h001)
                begin
                    nxt_state.fsm = AMD_START;
                end
                else
                begin
                    nxt_state.settle_cnt = state_ff.settle_cnt - 9'h001;
                end
            end
            AMD_START:
            begin
                nxt_state.adc_start = 1'b1;
                nxt_state.fsm = AMD_WAIT;
            end
            AMD_WAIT:
            begin
                if (done_edge)
                begin
                    nxt_state.fsm = AMD_EVAL;
                end
            end
            AMD_EVAL:
            begin
                nxt_state.fsm = AMD_START;
                kept = state_ff.trial;
                case (state_ff.job)
                    AMD_JOB_UNMOD:
                    begin
                        nxt_state.adc_out = state_ff.data_s2; // RULE7
                        quot = {state_ff.data_s2, 6'h00} / {7'h00, 1'b1,
                            state_ff.depth_ctrl[`AMD_BIT_RATIO_HI:`AMD_BIT_RATIO_LO]};
                        nxt_state.target = quot[7:0]; // RULE2 RULE3 RULE8
                        nxt_state.job = AMD_JOB_SAR;
                        nxt_state.bit_idx = 3'h7; // RULE20
                        nxt_state.trial = 8'h80;
                    end
                    AMD_JOB_SAR:
                    begin
                        if (state_ff.data_s2 < state_ff.target) // RULE9
                        begin
                            kept[state_ff.bit_idx] = 1'b0;
                        end
                        if (state_ff.bit_idx == 3'h0)
                        begin
                            nxt_state.display = kept; // RULE10
                            nxt_state.depth_done = 1'b1; // RULE21
                            nxt_state.fsm = AMD_IDLE;
                        end
                        else
                        begin
                            kept[state_ff.bit_idx - 3'h1] = 1'b1; // RULE20
                            nxt_state.bit_idx = state_ff.bit_idx - 3'h1;
                        end
                        nxt_state.trial = kept;
                    end
                    AMD_JOB_MANUAL:
                    begin
                        nxt_state.adc_out = state_ff.data_s2; // RULE16
                        nxt_state.meas_done = 1'b1;
                        nxt_state.fsm = AMD_IDLE;
                    end
                    default:
                    begin
                        if (state_ff.data_s2 > state_ff.ant_target)
                        begin
                            kept[state_ff.bit_idx] = 1'b0;
                        end
                        if (state_ff.bit_idx == 3'h0)
                        begin
                            diff = (state_ff.data_s2 > state_ff.ant_target) ?
                                state_ff.data_s2 - state_ff.ant_target :
                                state_ff.ant_target - state_ff.data_s2;
                            nxt_state.ant_display = {(diff > `AMD_ANT_TOL), kept[3:0]};
                            nxt_state.ant_done = 1'b1;
                            nxt_state.fsm = AMD_IDLE;
                        end
                        else
                        begin
                            kept[state_ff.bit_idx - 3'h1] = 1'b1;
                            nxt_state.bit_idx = state_ff.bit_idx - 3'h1;
                        end
                        nxt_state.trial = kept;
                    end
                endcase
            end
            default:
            begin
                nxt_state.fsm = AMD_IDLE;
            end
        endcase

        // Segment disable code driven onto both antenna drivers.
        if (busy && (state_ff.job == AMD_JOB_UNMOD || state_ff.job == AMD_JOB_SAR))
        begin
            level = (state_ff.job == AMD_JOB_SAR) ? state_ff.trial : state_ff.normal_lvl;
        end
        else if (tx_am_modulate)
        begin
            level = state_ff.depth_ctrl[`AMD_BIT_SOURCE] ?
                state_ff.mod_lvl : state_ff.display; // RULE10 RULE13
        end
        else
        begin
            level = state_ff.normal_lvl; // RULE5
        end
        nxt_state.drv.seg_on_a = ~level; // RULE5
        nxt_state.drv.seg_on_b = ~level;
        nxt_state.drv.tx_enable = state_ff.tx_on |
            (busy && state_ff.job != AMD_JOB_MANUAL); // RULE7
    end

    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= '0;
            state_ff.fsm <= AMD_IDLE;
            state_ff.drv.seg_on_a <= 8'hff;
            state_ff.drv.seg_on_b <= 8'hff;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    logic [3:0] trim_src;

    // Manual control overrides the last automatic result.
    assign trim_src = state_ff.ant_ctrl[`AMD_BIT_ANT_MANUAL] ? state_ff.ant_ctrl[3:0] :
        (state_ff.fsm != AMD_IDLE && state_ff.job == AMD_JOB_ANT) ?
        state_ff.trial[3:0] : state_ff.ant_display[3:0]; // RULE19
    assign tuning_switch_bank_a = trim_src; // RULE18
    assign tuning_switch_bank_b = trim_src; // RULE18

    assign prdata = state_ff.prdata;
    assign pready = 1'b1;
    assign pslverr = state_ff.pslverr & psel & penable;
    assign adc_req.start = state_ff.adc_start;
    assign adc_req.phase_sel = (state_ff.job == AMD_JOB_ANT);
    assign tx_enable = state_ff.drv.tx_enable;
    assign antenna_driver_out_a = state_ff.drv.seg_on_a;
    assign antenna_driver_out_b = state_ff.drv.seg_on_b;

endmodule

/* tb/amd_depth_cal_sva.sv */
`timescale 1ns/10ps
`include "amd_params.svh"

module amd_depth_cal_sva
    import amd_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic tx_am_modulate, // Modulated level request
    input wire logic adc_done, // Conversion finished
    input wire logic [7:0] adc_data, // Conversion result
    input wire amd_adc_req_type adc_req, // Conversion request
    input wire logic tx_enable, // Transmitter on
    input wire logic [7:0] antenna_driver_out_a, // Segments, driver a
    input wire logic [7:0] antenna_driver_out_b, // Segments, driver b
    input wire logic [3:0] tuning_switch_bank_a, // Tuning, bank a
    input wire logic [3:0] tuning_switch_bank_b // Tuning, bank b
);
    logic src_ff;
    logic [7:0] mod_ff;
    logic [9:0] settle_ff;
    logic wr_acc;
    logic cal_wr;

    assign wr_acc = psel && penable && pwrite;
    assign cal_wr = wr_acc && (paddr == `AMD_OFS_COMMAND) && pwdata[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Shadows of the written fields and the settle span.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_ff <= 1'b0;
            mod_ff <= 8'h00;
            settle_ff <= 10'h000;
        end
        else
        begin
            if (wr_acc && paddr == `AMD_OFS_DEPTH_CTRL)
                src_ff <= pwdata[7];
            if (wr_acc && paddr == `AMD_OFS_MOD_LVL)
                mod_ff <= pwdata[7:0];
            if (cal_wr && !src_ff)
                settle_ff <= 10'h001;
            else if (settle_ff != 10'h000 && settle_ff != 10'h3ff)
                settle_ff <= settle_ff + 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence auto_cal_req;
        cal_wr && !src_ff;
    endsequence

    sequence manual_mod_steady;
        (tx_am_modulate && src_ff && $stable(mod_ff))[*3];
    endsequence

    a_banks_equal: assert property (tuning_switch_bank_a == tuning_switch_bank_b)
        else $error("tuning banks differ");
    a_drivers_equal: assert property (antenna_driver_out_a == antenna_driver_out_b)
        else $error("driver segment sets differ");
    a_start_pulse: assert property (adc_req.start |=> !adc_req.start)
        else $error("converter start longer than one cycle");
    a_cal_tx_on: assert property (auto_cal_req |-> ##[1:3] tx_enable[*8])
        else $error("transmitter not on after calibrate");
    a_settle_time: assert property ((settle_ff != 10'h000 && settle_ff < 10'h186)
        |-> !adc_req.start)
        else $error("measurement before carrier settled");
    a_refuse_source: assert property ((cal_wr && src_ff && !tx_enable)
        |=> !tx_enable[*8])
        else $error("calibration ran with source bit set");
    a_manual_drive: assert property (manual_mod_steady
        |-> antenna_driver_out_a == ~mod_ff)
        else $error("modulated drive not from written level");
    a_unmapped_err: assert property ((psel && penable && paddr > `AMD_OFS_ANT_DISPLAY)
        |-> pslverr && pready)
        else $error("unmapped access without error");
endmodule

bind amd_depth_cal amd_depth_cal_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_am_modulate(tx_am_modulate),
    .adc_done(adc_done), .adc_data(adc_data), .adc_req(adc_req), .tx_enable(tx_enable),
    .antenna_driver_out_a(antenna_driver_out_a), .antenna_driver_out_b(antenna_driver_out_b),
    .tuning_switch_bank_a(tuning_switch_bank_a), .tuning_switch_bank_b(tuning_switch_bank_b));

/* tb/amd_analog_model.sv */
`timescale 1ns/10ps

module amd_analog_model
    import amd_pkg::*;
#(
    parameter int CONV_CYC = 6
)
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire amd_adc_req_type adc_req, // Conversion request
    input wire logic tx_enable, // Transmitter on
    input wire logic [7:0] drive_seg, // Segment enables
    input wire logic [3:0] tune_sw, // Tuning switch drive
    output logic adc_done, // Conversion finished
    output logic [7:0] adc_data // Conversion result
);
    int cnt;
    int hold;
    logic phase_ff;

    // Amplitude follows the enabled segments; data is inverted once done falls.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 0;
            hold <= 0;
            phase_ff <= 1'b0;
            adc_done <= 1'b0;
            adc_data <= 8'h5a;
        end
        else
        begin
            if (adc_req.start)
            begin
                cnt <= CONV_CYC;
                phase_ff <= adc_req.phase_sel;
            end
            else if (cnt == 2)
            begin
                adc_data <= phase_ff ? {tune_sw, 4'h0} : (tx_enable ? drive_seg : 8'h00);
                cnt <= 1;
            end
            else if (cnt == 1)
            begin
                adc_done <= 1'b1;
                hold <= 4;
                cnt <= 0;
            end
            else if (cnt > 2)
                cnt <= cnt - 1;
            if (hold == 1)
            begin
                adc_done <= 1'b0;
                adc_data <= ~adc_data;
            end
            if (hold != 0)
                hold <= hold - 1;
        end
    end
endmodule

/* tb/test_am_depth_calibration.sv */
`timescale 1ns/10ps
`include "amd_params.svh"

module test_am_depth_calibration;
    import amd_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic tx_am_modulate = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic adc_done;
    logic [7:0] adc_data;
    amd_adc_req_type adc_req;
    logic tx_enable;
    logic [7:0] drv_a;
    logic [7:0] drv_b;
    logic [3:0] tune_a;
    logic [3:0] tune_b;
    logic [31:0] rdv;
    logic errv;
    int err_count = 0;
    int checks_done = 0;

    always #12.5 pclk = ~pclk;

    amd_depth_cal dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_am_modulate(tx_am_modulate), .adc_done(adc_done),
        .adc_data(adc_data), .adc_req(adc_req), .tx_enable(tx_enable),
        .antenna_driver_out_a(drv_a), .antenna_driver_out_b(drv_b),
        .tuning_switch_bank_a(tune_a), .tuning_switch_bank_b(tune_b));

    amd_analog_model model_u (.pclk(pclk), .presetn(presetn), .adc_req(adc_req),
        .tx_enable(tx_enable), .drive_seg(drv_a), .tune_sw(tune_a), .adc_done(adc_done),
        .adc_data(adc_data));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_flag(input int b);
        int n = 0;
        do
        begin
            apb(1'b0, `AMD_OFS_STATUS, 32'h0);
            n++;
        end
        while (rdv[b] !== 1'b1 && n < 1000);
        check("status flag", {31'h0, rdv[b]}, 32'h1);
        apb(1'b1, `AMD_OFS_STATUS, 32'h1 << b);
    endtask

    task automatic modulated(input logic [7:0] lvl);
        tx_am_modulate <= 1'b1;
        repeat (3) @(posedge pclk);
        check("modulated drive", {24'h0, drv_a}, {24'h0, ~lvl});
        tx_am_modulate <= 1'b0;
    endtask

    function automatic logic [7:0] exp_code(input int r);
        return 8'(255 - (255 * 64) / (64 + r));
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check("drivers at reset", {24'h0, drv_a}, 32'h000000ff);
        check("tuning at reset", {28'h0, tune_a}, 32'h0);
        apb(1'b0, `AMD_OFS_DEPTH_CTRL, 32'h0);
        check("depth control reset", rdv, 32'h0);
    endtask

    task automatic t_auto();
        int rl[3] = '{0, 14, 63};
        foreach (rl[i])
        begin
            apb(1'b1, `AMD_OFS_DEPTH_CTRL, 32'(rl[i] << 1));
            apb(1'b1, `AMD_OFS_COMMAND, 32'h1);
            wait_flag(`AMD_ST_DEPTH_DONE);
            apb(1'b0, `AMD_OFS_ADC_OUT, 32'h0);
            check("unmodulated amplitude", rdv, 32'h000000ff);
            apb(1'b0, `AMD_OFS_DISPLAY, 32'h0);
            check("display", rdv, {24'h0, exp_code(rl[i])});
            modulated(exp_code(rl[i]));
        end
    endtask

    task automatic t_source();
        apb(1'b1, `AMD_OFS_TX_CTRL, 32'h0);
        apb(1'b1, `AMD_OFS_DEPTH_CTRL, 32'h80);
        apb(1'b1, `AMD_OFS_COMMAND, 32'h1);
        repeat (20) @(posedge pclk);
        apb(1'b0, `AMD_OFS_STATUS, 32'h0);
        check("refused calibrate", {31'h0, rdv[`AMD_ST_DEPTH_DONE]}, 32'h0);
        apb(1'b1, `AMD_OFS_NORMAL_LVL, 32'h03);
        repeat (3) @(posedge pclk);
        check("normal drive", {24'h0, drv_a}, 32'h000000fc);
        apb(1'b1, `AMD_OFS_NORMAL_LVL, 32'h00);
    endtask

    task automatic t_manual();
        logic [7:0] best = 8'h00;
        logic [7:0] tgt;
        apb(1'b1, `AMD_OFS_TX_CTRL, 32'h1);
        apb(1'b1, `AMD_OFS_COMMAND, 32'h2);
        wait_flag(`AMD_ST_MEAS_DONE);
        apb(1'b0, `AMD_OFS_ADC_OUT, 32'h0);
        check("manual amplitude", rdv, 32'h000000ff);
        tgt = 8'((rdv * 64) / (64 + 96));
        for (int b = 7; b >= 0; b--)
        begin
            apb(1'b1, `AMD_OFS_NORMAL_LVL, 32'(best | (8'h1 << b)));
            apb(1'b1, `AMD_OFS_COMMAND, 32'h2);
            wait_flag(`AMD_ST_MEAS_DONE);
            apb(1'b0, `AMD_OFS_ADC_OUT, 32'h0);
            if (rdv[7:0] >= tgt)
                best = best | (8'h1 << b);
        end
        check("manual result", {24'h0, best}, {24'h0, exp_code(96)});
        apb(1'b1, `AMD_OFS_MOD_LVL, {24'h0, best});
        apb(1'b1, `AMD_OFS_NORMAL_LVL, 32'h0);
        modulated(best);
    endtask

    task automatic t_tuning();
        apb(1'b1, `AMD_OFS_ANT_CTRL, 32'h85);
        repeat (2) @(posedge pclk);
        check("manual tuning", {24'h0, tune_a, tune_b}, 32'h00000055);
        apb(1'b1, `AMD_OFS_ANT_CTRL, 32'h00);
        apb(1'b1, `AMD_OFS_ANT_TARGET, 32'h50);
        apb(1'b1, `AMD_OFS_COMMAND, 32'h4);
        wait_flag(`AMD_ST_ANT_DONE);
        apb(1'b0, `AMD_OFS_ANT_DISPLAY, 32'h0);
        check("antenna result", {28'h0, rdv[3:0]}, 32'h5);
    endtask

    task automatic t_unmapped();
        apb(1'b1, 8'h30, 32'hff);
        check("unmapped write error", {31'h0, errv}, 32'h1);
        apb(1'b0, 8'h30, 32'h0);
        check("unmapped read", {errv, rdv[30:0]}, 32'h80000000);
        apb(1'b0, `AMD_OFS_DEPTH_CTRL, 32'h0);
        check("control untouched", rdv, 32'h80);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_tuning();
        t_auto();
        t_source();
        t_manual();
        t_unmapped();
        complete_run();
    end

    initial
    begin
        #(25 * 60000);
        err_count++;
        $display("[FAIL] watchdog expected finish seen hang");
        complete_run();
    end
endmodule
